// file: hdl/fdm_counter.sv
`timescale 1ns/10ps
module fdm_counter #(
    parameter longint LIMIT = 10
) (
    input  wire logic sys_clk_in,
    input  wire logic nrst_in,
    input  wire logic run_in,
    output logic      expired_out
);
    import fdm_pkg::*;

    localparam int W = $clog2(LIMIT + 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    initial begin
        if (LIMIT < 1) $error("fdm_counter limit must be at least one");
    end

    // Counts while run is high, saturates; a drop restarts the count
    always_comb begin
        if (!run_in) begin
            cnt_d = '0;
        end else if (cnt_q != W'(LIMIT)) begin
            cnt_d = cnt_q + W'(1);
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign expired_out = (cnt_q == W'(LIMIT));
endmodule

// file: hdl/fdm_fault_manager.sv
`timescale 1ns/10ps
// Behaviour
// - Supply over/under flags; interrupt code 0101
// - Long dominant transmit disables transmitter, flags
// - Receive short or hot driver stops transmitter
// - High-side hot turns high side off, code 0010
// - Low-side hot turns low side off, code 0011
// - Driver status bit layout; thermal sets all
// - Drivers off until cleared and control written
// - Watchdog timeout or early clear in Normal resets, flags
// - Floating config pin selects internal timebase, flags
// - Core undervoltage in reset goes to sleep unless supply under is flagged
// - Interrupts only in normal, request, stop
// - Masked faults keep line high, no source
// - Transmitter restarts after fault gone, recessive
// - Request timeout forces reset then request again
module fdm_fault_manager #(
    parameter longint TX_DOM_LIMIT = fdm_pkg::TX_DOM_CYCLES,
    parameter longint NRQ_LIMIT    = fdm_pkg::NRQ_TMO_CYCLES
) (
    input  wire logic                sys_clk_in,
    input  wire logic                nrst_in,
    input  wire fdm_pkg::fdm_faults_t faults_in,
    input  wire logic                tx_data_in,
    input  wire logic                watchdog_timeout_in,
    input  wire logic                watchdog_clear_in,
    input  wire logic                watchdog_window_open_in,
    input  wire logic                goto_normal_in,
    input  wire logic                goto_stop_in,
    input  wire logic                wake_in,
    input  wire logic                overvoltage_shutdown_enable_in,
    input  wire logic                high_side_control_wr_in,
    input  wire logic                low_side_control_wr_in,
    input  wire fdm_pkg::fdm_mask_t  mask_in,
    input  wire logic                status_read_in,
    output fdm_pkg::fdm_status_t     status_out,
    output fdm_pkg::fdm_mode_t       mode_out,
    output logic                     irq_n_out,
    output logic                     host_reset_n_out,
    output logic                     tx_enable_out,
    output logic                     high_side_driver_enable_out,
    output logic                     low_side_driver_enable_out,
    output logic                     internal_timebase_out
);
    import fdm_pkg::*;

    initial begin
        if (TX_DOM_LIMIT < 1 || NRQ_LIMIT < 1) $error("fdm timing limits must be positive");
    end

    fdm_faults_t flt;
    fdm_sync #(.WIDTH($bits(fdm_faults_t))) u_sync (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .async_in   (faults_in),
        .sync_out   (flt)
    );

    logic tx_stuck;
    fdm_counter #(.LIMIT(TX_DOM_LIMIT)) u_transmit_stuck_flag (
        .sys_clk_in  (sys_clk_in),
        .nrst_in     (nrst_in),
        .run_in      (!tx_data_in),
        .expired_out (tx_stuck)
    );

    fdm_mode_t mode_q, mode_d;
    logic      nrq_expired;
    fdm_counter #(.LIMIT(NRQ_LIMIT)) u_nrq (
        .sys_clk_in  (sys_clk_in),
        .nrst_in     (nrst_in),
        .run_in      (mode_q == FDM_MODE_NREQ),
        .expired_out (nrq_expired)
    );

    fdm_status_t st_q, st_d;
    logic tx_off_q, tx_off_d;
    logic hs_off_q, hs_off_d;
    logic ls_off_q, ls_off_d;
    logic irq_q, irq_d;
    logic wd_fault;
    logic irq_allowed;
    logic hv_off;

    // Only faults in these modes may raise the interrupt
    function automatic logic irq_mode(input fdm_mode_t m);
        return (m == FDM_MODE_NORMAL) || (m == FDM_MODE_NREQ) || (m == FDM_MODE_STOP);
    endfunction

    assign irq_allowed = irq_mode(mode_q);
    assign wd_fault = (mode_q == FDM_MODE_NORMAL) &&
                      (watchdog_timeout_in || (watchdog_clear_in && !watchdog_window_open_in));
    assign hv_off = flt.supply_over && overvoltage_shutdown_enable_in &&
                    (mode_q == FDM_MODE_NORMAL);

    // Mode sequencing
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            FDM_MODE_RESET: begin
                if (flt.core_under && !st_q.supply_status[SUP_UNDER_BIT]) begin
                    mode_d = FDM_MODE_SLEEP;
                end else if (!flt.core_under) begin
                    mode_d = FDM_MODE_NREQ;
                end
            end
            FDM_MODE_NREQ: begin
                if (nrq_expired) begin
                    mode_d = FDM_MODE_RESET;
                end else if (goto_normal_in) begin
                    mode_d = FDM_MODE_NORMAL;
                end
            end
            FDM_MODE_NORMAL: begin
                if (wd_fault || flt.core_under) begin
                    mode_d = FDM_MODE_RESET;
                end else if (goto_stop_in) begin
                    mode_d = FDM_MODE_STOP;
                end
            end
            FDM_MODE_STOP: begin
                if (flt.core_under) mode_d = FDM_MODE_RESET;
                else if (wake_in) mode_d = FDM_MODE_NREQ;
            end
            FDM_MODE_SLEEP: begin
                if (wake_in) mode_d = FDM_MODE_RESET;
            end
            default: mode_d = FDM_MODE_RESET;
        endcase
    end

    // Status flags, shutdown latches and interrupt source
    always_comb begin
        st_d     = st_q;
        tx_off_d = tx_off_q;
        hs_off_d = hs_off_q;
        ls_off_d = ls_off_q;
        irq_d    = irq_q;
        // a read clears flags, new events win
        if (status_read_in) begin
            st_d     = '0;
            irq_d    = 1'b0;
        end
        if (flt.battery_fail) st_d.supply_status[SUP_BATTERY_FAIL_FLAG_BIT] = 1'b1;
        if (flt.core_thermal_warn) st_d.supply_status[SUP_THERM_BIT] = 1'b1;
        if (flt.supply_under) st_d.supply_status[SUP_UNDER_BIT] = 1'b1;
        if (flt.supply_over) st_d.supply_status[SUP_OVER_BIT] = 1'b1;
        if (flt.receive_short) st_d.bus_status[BUS_SHORT_BIT] = 1'b1;
        if (flt.bus_driver_hot) st_d.bus_status[BUS_HOT_BIT] = 1'b1;
        if (tx_stuck) st_d.bus_status[BUS_STUCK_BIT] = 1'b1;
        if (flt.receive_short || flt.bus_driver_hot || tx_stuck) begin
            tx_off_d = 1'b1;
        end else if (tx_data_in) begin
            tx_off_d = 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            if (flt.high_limit[i]) st_d.high_side_status[DRV_LIM1_BIT + 2*i] = 1'b1;
            if (flt.high_open[i]) st_d.high_side_status[DRV_OPEN1_BIT + 2*i] = 1'b1;
            if (flt.low_limit[i]) st_d.low_side_status[DRV_LIM1_BIT + 2*i] = 1'b1;
            if (flt.low_open[i]) st_d.low_side_status[DRV_OPEN1_BIT + 2*i] = 1'b1;
        end
        if (flt.high_side_hot) st_d.high_side_status = 4'hF;
        if (flt.low_side_hot) st_d.low_side_status = 4'hF;
        // re-enable by write once condition gone
        if (high_side_control_wr_in && !flt.high_side_hot && !hv_off) hs_off_d = 1'b0;
        if (low_side_control_wr_in && !flt.low_side_hot && !hv_off) ls_off_d = 1'b0;
        if (flt.high_side_hot || hv_off) hs_off_d = 1'b1;
        if (flt.low_side_hot || hv_off) ls_off_d = 1'b1;
        if (wd_fault) st_d.watchdog_status[WD_TO_BIT] = 1'b1;
        if (flt.watchdog_config_floating) st_d.watchdog_status[WD_ERR_BIT] = 1'b1;
        // only in allowed modes; masked ones skip source
        if (irq_allowed) begin
            if (!mask_in.high && flt.high_side_hot) begin
                st_d.interrupt_source = SRC_HIGH;
                irq_d = 1'b1;
            end else if (!mask_in.low && flt.low_side_hot) begin
                st_d.interrupt_source = SRC_LOW;
                irq_d = 1'b1;
            end else if (!mask_in.bus && (flt.receive_short || flt.bus_driver_hot)) begin
                st_d.interrupt_source = SRC_BUS;
                irq_d = 1'b1;
            end else if (!mask_in.supply &&
                         (flt.supply_over || flt.supply_under || flt.core_thermal_warn)) begin
                st_d.interrupt_source = SRC_SUPPLY;
                irq_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_q   <= FDM_MODE_RESET;
            st_q     <= '0;
            tx_off_q <= 1'b0;
            hs_off_q <= 1'b0;
            ls_off_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            mode_q   <= mode_d;
            st_q     <= st_d;
            tx_off_q <= tx_off_d;
            hs_off_q <= hs_off_d;
            ls_off_q <= ls_off_d;
            irq_q    <= irq_d;
        end
    end

    // Outputs; the source field reads zero while no interrupt is pending
    assign status_out                  = st_q;
    assign mode_out                    = mode_q;
    assign irq_n_out                   = !(irq_q && irq_allowed);
    assign host_reset_n_out            = (mode_q != FDM_MODE_RESET);
    assign tx_enable_out               = !tx_off_q;
    assign high_side_driver_enable_out = !hs_off_q;
    assign low_side_driver_enable_out  = !ls_off_q;
    assign internal_timebase_out       = st_q.watchdog_status[WD_ERR_BIT];

    // supply over raises code 0101 next cycle
    property p_supply_irq;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (flt.supply_over && irq_allowed && !mask_in.supply && !flt.high_side_hot &&
         !flt.low_side_hot && !flt.receive_short && !flt.bus_driver_hot && !status_read_in)
        |=> (st_q.interrupt_source == SRC_SUPPLY) && st_q.supply_status[SUP_OVER_BIT];
    endproperty
    a_supply_irq: assert property (p_supply_irq) else $error("supply interrupt missing");

    property p_tx_stuck;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        tx_stuck |=> !tx_enable_out && st_q.bus_status[BUS_STUCK_BIT];
    endproperty
    a_tx_stuck: assert property (p_tx_stuck) else $error("stuck transmit not handled");

    property p_bus_fault;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (flt.receive_short || flt.bus_driver_hot) |=> !tx_enable_out;
    endproperty
    a_bus_fault: assert property (p_bus_fault) else $error("bus fault kept transmitter on");

    property p_hs_off;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        flt.high_side_hot |=> !high_side_driver_enable_out && (st_q.high_side_status == 4'hF);
    endproperty
    a_hs_off: assert property (p_hs_off) else $error("high side not shut down");

    property p_ls_off;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        flt.low_side_hot |=> !low_side_driver_enable_out && (st_q.low_side_status == 4'hF);
    endproperty
    a_ls_off: assert property (p_ls_off) else $error("low side not shut down");

    // high side stays off without a write
    property p_hs_hold;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (!high_side_driver_enable_out && !high_side_control_wr_in) |=> !high_side_driver_enable_out;
    endproperty
    a_hs_hold: assert property (p_hs_hold) else $error("high side re-enabled without write");

    // low side stays off without a write
    property p_ls_hold;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (!low_side_driver_enable_out && !low_side_control_wr_in) |=> !low_side_driver_enable_out;
    endproperty
    a_ls_hold: assert property (p_ls_hold) else $error("low side on without write");

    property p_wd;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        wd_fault |=> !host_reset_n_out && st_q.watchdog_status[WD_TO_BIT];
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog fault not acted on");

    property p_irq_mode;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !irq_mode(mode_q) |-> irq_n_out;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("interrupt in forbidden mode");

    property p_nrq;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (mode_q == FDM_MODE_NREQ && nrq_expired) |=> (mode_q == FDM_MODE_RESET);
    endproperty
    a_nrq: assert property (p_nrq) else $error("request timeout ignored");
endmodule

// file: hdl/fdm_pkg.sv
package fdm_pkg;

    // Bit positions in the status registers
    localparam int SUP_BATTERY_FAIL_FLAG_BIT = 0;
    localparam int SUP_THERM_BIT   = 1;
    localparam int SUP_UNDER_BIT   = 2;
    localparam int SUP_OVER_BIT    = 3;
    localparam int BUS_HOT_BIT     = 1;
    localparam int BUS_STUCK_BIT   = 2;
    localparam int BUS_SHORT_BIT   = 3;
    localparam int DRV_LIM1_BIT    = 0;
    localparam int DRV_OPEN1_BIT   = 1;
    localparam int DRV_LIM2_BIT    = 2;
    localparam int DRV_OPEN2_BIT   = 3;
    localparam int WD_ERR_BIT      = 2;
    localparam int WD_TO_BIT       = 3;

    // Status register reset value
    localparam logic [3:0] STATUS_RST = 4'h0;

    // Interrupt source codes
    localparam logic [3:0] SRC_NONE   = 4'h0;
    localparam logic [3:0] SRC_HIGH   = 4'h2;
    localparam logic [3:0] SRC_LOW    = 4'h3;
    localparam logic [3:0] SRC_BUS    = 4'h4;
    localparam logic [3:0] SRC_SUPPLY = 4'h5;

    // Timing
    localparam longint CLK_HZ         = 10_000_000;
    localparam longint TX_DOM_MS      = 1000;
    localparam longint TX_DOM_CYCLES  = (TX_DOM_MS * CLK_HZ + 999) / 1000;
    localparam longint NRQ_TMO_MS     = 150;
    localparam longint NRQ_TMO_CYCLES = (NRQ_TMO_MS * CLK_HZ) / 1000;
    localparam int     SYNC_STAGES    = 2;

    // Operating modes, one-hot
    typedef enum logic [4:0] {
        FDM_MODE_RESET  = 5'b00001,
        FDM_MODE_NREQ   = 5'b00010,
        FDM_MODE_NORMAL = 5'b00100,
        FDM_MODE_STOP   = 5'b01000,
        FDM_MODE_SLEEP  = 5'b10000
    } fdm_mode_t;

    // Raw analog fault indications
    typedef struct packed {
        logic battery_fail;
        logic supply_over;
        logic supply_under;
        logic core_thermal_warn;
        logic core_under;
        logic receive_short;
        logic bus_driver_hot;
        logic high_side_hot;
        logic low_side_hot;
        logic [1:0] high_open;
        logic [1:0] high_limit;
        logic [1:0] low_open;
        logic [1:0] low_limit;
        logic watchdog_config_floating;
    } fdm_faults_t;

    // Interrupt masks
    typedef struct packed {
        logic supply;
        logic bus;
        logic high;
        logic low;
    } fdm_mask_t;

    // Status register group
    typedef struct packed {
        logic [3:0] supply_status;
        logic [3:0] bus_status;
        logic [3:0] high_side_status;
        logic [3:0] low_side_status;
        logic [3:0] watchdog_status;
        logic [3:0] interrupt_source;
    } fdm_status_t;

endpackage

// file: hdl/fdm_sync.sv
`timescale 1ns/10ps
module fdm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import fdm_pkg::*;

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    initial begin
        if (WIDTH < 1) $error("fdm_sync width must be positive");
    end

    // First stage feeds only the second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

// file: verification/fdm_host_model.sv
`timescale 1ns/10ps
module fdm_host_model (
    input  wire logic               sys_clk_in,
    input  wire logic               nrst_in,
    input  wire fdm_pkg::fdm_mode_t mode_in,
    input  wire logic               auto_in,
    output logic                    goto_normal_out
);
    import fdm_pkg::*;

    logic [2:0] wait_q;

    // Firmware answers Normal Request a few cycles late; counter saturates so
    // a host told to stay quiet never fires a stray command
    // command Normal in time
    always @(negedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_q <= 3'h0;
            goto_normal_out <= 1'h0;
        end else begin
            goto_normal_out <= 1'h0;
            if (mode_in !== FDM_MODE_NREQ) begin
                wait_q <= 3'h0;
            end else if (wait_q != 3'h7) begin
                wait_q <= wait_q + 3'h1;
                goto_normal_out <= auto_in && (wait_q == 3'h4);
            end
        end
    end
endmodule

// file: verification/tb_fault_detect_manager.sv
`timescale 1ns/10ps
module tb_fault_detect_manager;
    import fdm_pkg::*;

    typedef struct packed {
        fdm_faults_t f;
        fdm_mask_t   m;
        logic [15:0] st;
        logic [3:0]  src;
        logic        irq;
        logic [2:0]  en;
    } fdm_row_t;

    logic        sys_clk_in;
    logic        nrst_in;
    fdm_faults_t faults;
    fdm_mask_t   mask;
    logic        tx_data, wd_to, wd_clr, wd_win, goto_stop, wake, ov_en;
    logic        hs_wr, ls_wr, rd, auto_nrm, goto_normal;
    fdm_status_t status;
    fdm_mode_t   mode;
    logic        irq_n, host_rst_n, tx_en, hs_en, ls_en, int_tb;
    int          err_total, n_tests, cyc_cnt;
    fdm_row_t    rows [13];

    // Free-running 10 MHz clock
    initial begin
        sys_clk_in = 1'h0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    // Short counts keep the stuck-transmit and request timeouts quick
    fdm_fault_manager #(.TX_DOM_LIMIT(20), .NRQ_LIMIT(30)) dut (
        .sys_clk_in                     (sys_clk_in),
        .nrst_in                        (nrst_in),
        .faults_in                      (faults),
        .tx_data_in                     (tx_data),
        .watchdog_timeout_in            (wd_to),
        .watchdog_clear_in              (wd_clr),
        .watchdog_window_open_in        (wd_win),
        .goto_normal_in                 (goto_normal),
        .goto_stop_in                   (goto_stop),
        .wake_in                        (wake),
        .overvoltage_shutdown_enable_in (ov_en),
        .high_side_control_wr_in        (hs_wr),
        .low_side_control_wr_in         (ls_wr),
        .mask_in                        (mask),
        .status_read_in                 (rd),
        .status_out                     (status),
        .mode_out                       (mode),
        .irq_n_out                      (irq_n),
        .host_reset_n_out               (host_rst_n),
        .tx_enable_out                  (tx_en),
        .high_side_driver_enable_out    (hs_en),
        .low_side_driver_enable_out     (ls_en),
        .internal_timebase_out          (int_tb)
    );

    fdm_host_model host (
        .sys_clk_in      (sys_clk_in),
        .nrst_in         (nrst_in),
        .mode_in         (mode),
        .auto_in         (auto_nrm),
        .goto_normal_out (goto_normal)
    );

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle strobes, held across exactly one sampling edge
    task automatic host_read();
        rd = 1'h1;
        cyc(1);
        rd = 1'h0;
    endtask

    task automatic host_write();
        hs_wr = 1'h1;
        ls_wr = 1'h1;
        cyc(1);
        hs_wr = 1'h0;
        ls_wr = 1'h0;
    endtask

    // Bounded wait so a stuck mode shows up as a mismatch, not a hang
    task automatic wait_mode(input fdm_mode_t m, input int lim);
        int k;
        k = 0;
        while (mode !== m && k < lim) begin
            cyc(1);
            k++;
        end
        check("mode", mode, m);
    endtask

    task automatic final_report();
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole run needs well under 2000 cycles
    always @(posedge sys_clk_in) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        {faults, mask, wd_to, wd_clr, goto_stop, wake, ov_en} = '0;
        {hs_wr, ls_wr, rd, err_total, n_tests, cyc_cnt} = '0;
        {tx_data, wd_win, auto_nrm} = 3'h7;
        nrst_in = 1'h0;
        // Fault, mask, status {supply,bus,high,low}, source, irq_n, {tx,hs,ls}
        rows = '{'{18'h1_0000, 4'h0, 16'h8000, 4'h5, 1'h0, 3'h7},
                 '{18'h0_8000, 4'h0, 16'h4000, 4'h5, 1'h0, 3'h7},
                 '{18'h0_1000, 4'h0, 16'h0800, 4'h4, 1'h0, 3'h3},
                 '{18'h0_0800, 4'h0, 16'h0200, 4'h4, 1'h0, 3'h3},
                 '{18'h0_0400, 4'h0, 16'h00F0, 4'h2, 1'h0, 3'h5},
                 '{18'h0_0200, 4'h0, 16'h000F, 4'h3, 1'h0, 3'h6},
                 '{18'h0_0080, 4'h0, 16'h0020, 4'h0, 1'h1, 3'h7},
                 '{18'h0_0040, 4'h0, 16'h0040, 4'h0, 1'h1, 3'h7},
                 '{18'h0_0010, 4'h0, 16'h0008, 4'h0, 1'h1, 3'h7},
                 '{18'h0_0002, 4'h0, 16'h0001, 4'h0, 1'h1, 3'h7},
                 '{18'h1_0000, 4'h8, 16'h8000, 4'h0, 1'h1, 3'h7},
                 '{18'h0_0400, 4'h2, 16'h00F0, 4'h0, 1'h1, 3'h5},
                 '{18'h0_8400, 4'h0, 16'h40F0, 4'h2, 1'h0, 3'h5}};
        cyc(20);
        check("irq in reset", {irq_n, host_rst_n}, 2'h2);
        nrst_in = 1'h1;
        wait_mode(FDM_MODE_NREQ, 10);
        wait_mode(FDM_MODE_NORMAL, 20);
        // Table of single faults and one paired fault; each is cleared and re-armed by the host
        foreach (rows[i]) begin
            mask = rows[i].m;
            faults = rows[i].f;
            cyc(4);
            check("status", status[23:8], rows[i].st);
            check("source", status.interrupt_source, rows[i].src);
            check("irq_n", irq_n, rows[i].irq);
            check("enables", {tx_en, hs_en, ls_en}, rows[i].en);
            faults = '0;
            cyc(4);
            host_write();
            host_read();
            check("cleared", {status, irq_n}, {24'h00_0000, 1'h1});
            check("restart", {tx_en, hs_en, ls_en}, 3'h7);
        end
        // Synchroniser latency is exactly two flops plus the flag register
        faults.supply_under = 1'h1;
        cyc(2);
        check("sync early", status.supply_status, 4'h0);
        cyc(1);
        check("sync late", status.supply_status, 4'h4);
        faults = '0;
        cyc(4);
        host_read();
        // Transmit held dominant past the limit
        tx_data = 1'h0;
        cyc(15);
        check("stuck early", {status.bus_status, tx_en}, 5'h01);
        cyc(10);
        check("stuck", {status.bus_status, tx_en, irq_n}, 6'h11);
        tx_data = 1'h1;
        cyc(2);
        check("tx back", tx_en, 1'h1);
        host_read();
        // Overvoltage shutdown: a write while the condition lasts is ignored
        ov_en = 1'h1;
        faults.supply_over = 1'h1;
        cyc(4);
        check("ov off", {hs_en, ls_en}, 2'h0);
        host_write();
        cyc(2);
        check("early write", {hs_en, ls_en}, 2'h0);
        faults = '0;
        cyc(4);
        check("stay off", {hs_en, ls_en}, 2'h0);
        host_write();
        check("ov back", {hs_en, ls_en}, 2'h3);
        ov_en = 1'h0;
        host_read();
        faults.watchdog_config_floating = 1'h1;
        cyc(4);
        check("wd err", {status.watchdog_status, int_tb}, 5'h09);
        faults = '0;
        cyc(4);
        host_read();
        // Watchdog timeout, then a silent host lets the request time out
        auto_nrm = 1'h0;
        wd_to = 1'h1;
        cyc(1);
        wd_to = 1'h0;
        wait_mode(FDM_MODE_RESET, 10);
        check("host reset", host_rst_n, 1'h0);
        wait_mode(FDM_MODE_NREQ, 50);
        wait_mode(FDM_MODE_RESET, 40);
        auto_nrm = 1'h1;
        wait_mode(FDM_MODE_NREQ, 50);
        wait_mode(FDM_MODE_NORMAL, 20);
        check("wd timeout", status.watchdog_status, 4'h8);
        host_read();
        // Clear while the window is closed, then a legal one
        wd_win = 1'h0;
        wd_clr = 1'h1;
        cyc(1);
        wd_clr = 1'h0;
        wait_mode(FDM_MODE_RESET, 10);
        wait_mode(FDM_MODE_NORMAL, 100);
        check("early clear", status.watchdog_status, 4'h8);
        host_read();
        wd_win = 1'h1;
        wd_clr = 1'h1;
        cyc(1);
        wd_clr = 1'h0;
        cyc(10);
        check("good clear", {mode, status.watchdog_status}, {FDM_MODE_NORMAL, 4'h0});
        // Stop still interrupts; core undervoltage then sends the part to sleep
        goto_stop = 1'h1;
        cyc(1);
        goto_stop = 1'h0;
        wait_mode(FDM_MODE_STOP, 10);
        faults.low_side_hot = 1'h1;
        cyc(4);
        check("stop irq", {irq_n, status.interrupt_source}, 5'h03);
        faults = '0;
        cyc(4);
        host_read();
        faults.core_under = 1'h1;
        wait_mode(FDM_MODE_SLEEP, 20);
        faults.supply_over = 1'h1;
        cyc(4);
        check("sleep irq", irq_n, 1'h1);
        faults = '0;
        cyc(4);
        wake = 1'h1;
        cyc(1);
        wake = 1'h0;
        wait_mode(FDM_MODE_NREQ, 50);
        wait_mode(FDM_MODE_NORMAL, 20);
        // The low-side shutdown from Stop outlives sleep and wake until written
        check("ls held", {hs_en, ls_en}, 2'h2);
        host_read();
        // Second reset mid-run, with a flag, an interrupt and a shutdown pending
        faults.supply_under = 1'h1;
        cyc(4);
        check("pending", {irq_n, status.supply_status}, 5'h04);
        nrst_in = 1'h0;
        cyc(2);
        check("rst mode", mode, FDM_MODE_RESET);
        check("rst status", status, 24'h00_0000);
        check("rst pins", {irq_n, host_rst_n, tx_en, hs_en, ls_en}, 5'h17);
        faults = '0;
        nrst_in = 1'h1;
        wait_mode(FDM_MODE_NREQ, 10);
        wait_mode(FDM_MODE_NORMAL, 20);
        final_report();
    end
endmodule
